// >>> design/hall_regs_pkg.sv
// Constants for the threshold, conversion status and result register slice.
// Assumes a 4-bit word address from the serial framer and 16-bit register data.
package hall_regs_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] ADDR_Z_THR = 4'h6;
   localparam logic [3:0] ADDR_T_THR = 4'h7;
   localparam logic [3:0] ADDR_CONV = 4'h8;
   localparam logic [3:0] ADDR_X_RES = 4'h9;
   localparam logic [3:0] ADDR_Y_RES = 4'ha;
   localparam logic [3:0] ADDR_Z_RES = 4'hb;
   localparam logic [3:0] ADDR_T_RES = 4'hc;
   localparam logic [3:0] ADDR_AFE = 4'hd;
   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_Z_THR = 16'h7d83;
   localparam logic [15:0] RST_T_THR = 16'h6732;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_AFE = 16'h8000;
   // ==========================================================
   // Field positions
   localparam int UPPER_MSB = 15;
   localparam int UPPER_LSB = 8;
   localparam int LOWER_MSB = 7;
   localparam int LOWER_LSB = 0;
   localparam int CONV_RDY_BIT = 13;
   localparam int CONV_CUR_MSB = 12;
   localparam int CONV_CUR_LSB = 8;
   localparam int CONV_SET_MSB = 6;
   localparam int CONV_SET_LSB = 4;
   localparam int CONV_SUM_MSB = 1;
   localparam int CONV_SUM_LSB = 0;
   localparam int AFE_PWRUP_BIT = 15;
   localparam int AFE_DIAG_MSB = 12;
   localparam int AFE_DIAG_LSB = 8;
   localparam int AFE_SUPPLY_MSB = 1;
   localparam int AFE_SUPPLY_LSB = 0;
   // Mask of bits that exist in the front-end status register.
   localparam logic [15:0] AFE_MASK = 16'h9f03;
endpackage

// >>> design/threshold_result_status_regs.sv
// Threshold, conversion status, result and front-end status registers.
// Assumes the serial framer, conversion engine and fault monitors share clk_sys;
// their strobes are single-cycle pulses and need no synchroniser.
// ==========================================================
// Notes on behaviour
// - Z upper limit: writable signed byte, high.
// - Z lower limit: writable signed byte, low.
// - Limit code scales as range over 128.
// - Temperature limits: signed bytes, high and low.
// - Ready bit 13 set on valid data.
// - Bit 12 flags current angle data.
// - Bit 11 flags current temperature data.
// - Bits 10..8 flag current Z, Y, X.
// - Three-bit rolling count of completed sets.
// - Bits 1..0 encode front-end and system flags.
// - Four read-only results, reset to zero.
// - Front-end status resets with top bit.
// - Reading front-end status clears power-up bit.
// - Latched mode holds alert until read.
// - One to four crossings before alert.
`timescale 1ns/1ps
module threshold_result_status_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register access from the serial framer
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Conversion engine
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [4:0] chan_current,
   input wire logic [15:0] x_sample_in,
   input wire logic [15:0] y_sample_in,
   input wire logic [15:0] z_sample_in,
   input wire logic [15:0] temp_sample_in,
   input wire logic [7:0] temp_code_in,
   // Fault monitors and system status
   input wire logic [6:0] afe_fault,
   input wire logic sys_flag_any,
   // Alert configuration
   input wire logic alert_latch,
   input wire logic status_alert_en,
   input wire logic z_limit_alert_en,
   input wire logic temp_limit_alert_en,
   input wire logic [1:0] limit_crossing_count,
   // Outputs toward the alert logic
   output logic [7:0] z_upper_limit,
   output logic [7:0] z_lower_limit,
   output logic [7:0] temp_upper_limit,
   output logic [7:0] temp_lower_limit,
   output logic [1:0] alert_cause_summary,
   output logic alert_resp
);

   // ==========================================================
   // Decoding
   // A read of a status or result register acknowledges a latched alert.
   function automatic logic is_ack_addr(input logic [3:0] a);
      is_ack_addr = (a >= hall_regs_pkg::ADDR_CONV) && (a <= hall_regs_pkg::ADDR_AFE);
   endfunction

   logic [15:0] z_thr_r;
   logic [15:0] t_thr_r;
   logic rdy_r;
   logic [4:0] cur_r;
   logic [2:0] set_cnt_r;
   logic [1:0] summary_r;
   logic [15:0] x_res_r;
   logic [15:0] y_res_r;
   logic [15:0] z_res_r;
   logic [15:0] t_res_r;
   logic [15:0] afe_r;
   logic [15:0] afe_set;
   logic [15:0] conv_word;
   logic [15:0] rdata_nxt;
   logic [15:0] rdata_r;
   logic [2:0] z_run_r;
   logic [2:0] t_run_r;
   logic z_beyond;
   logic t_beyond;
   logic [2:0] need;
   logic alert_cond;
   logic alert_r;
   logic ack_rd;

   // ==========================================================
   // Threshold registers
   // Only the two limit registers accept writes; every other offset drops them.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         z_thr_r <= hall_regs_pkg::RST_Z_THR;
         t_thr_r <= hall_regs_pkg::RST_T_THR;
      end else if (reg_wr) begin
         if (reg_addr == hall_regs_pkg::ADDR_Z_THR) begin
            z_thr_r <= reg_wdata;
         end
         if (reg_addr == hall_regs_pkg::ADDR_T_THR) begin
            t_thr_r <= reg_wdata;
         end
      end
   end

   // ==========================================================
   // Conversion progress
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdy_r <= 1'b0;
         cur_r <= 5'h00;
         set_cnt_r <= 3'h0;
      end else if (conv_done) begin
         rdy_r <= 1'b1;
         cur_r <= chan_current;
         set_cnt_r <= set_cnt_r + 3'h1;
      end else if (conv_start) begin
         // Results still hold the last set until the new one lands.
         rdy_r <= 1'b0;
         cur_r <= 5'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         summary_r <= 2'h0;
      end else begin
         summary_r <= {sys_flag_any, |afe_r};
      end
   end

   // ==========================================================
   // Result registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         x_res_r <= hall_regs_pkg::RST_ZERO;
         y_res_r <= hall_regs_pkg::RST_ZERO;
         z_res_r <= hall_regs_pkg::RST_ZERO;
         t_res_r <= hall_regs_pkg::RST_ZERO;
      end else if (conv_done) begin
         x_res_r <= x_sample_in;
         y_res_r <= y_sample_in;
         z_res_r <= z_sample_in;
         t_res_r <= temp_sample_in;
      end
   end

   // ==========================================================
   // Front-end status
   assign afe_set = {1'b0, 2'b00, afe_fault[6:2], 6'h00, afe_fault[1:0]};

   // A fault arriving in the read cycle survives the clear.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         afe_r <= hall_regs_pkg::RST_AFE;
      end else if (reg_rd && reg_addr == hall_regs_pkg::ADDR_AFE) begin
         afe_r <= afe_set & hall_regs_pkg::AFE_MASK;
      end else begin
         afe_r <= (afe_r | afe_set) & hall_regs_pkg::AFE_MASK;
      end
   end

   // ==========================================================
   // Read path
   assign conv_word = {2'b00, rdy_r, cur_r, 1'b0, set_cnt_r, 2'b00, summary_r};

   always_comb begin
      rdata_nxt = 16'h0000;
      unique case (reg_addr)
         hall_regs_pkg::ADDR_Z_THR: rdata_nxt = z_thr_r;
         hall_regs_pkg::ADDR_T_THR: rdata_nxt = t_thr_r;
         hall_regs_pkg::ADDR_CONV: rdata_nxt = conv_word;
         hall_regs_pkg::ADDR_X_RES: rdata_nxt = x_res_r;
         hall_regs_pkg::ADDR_Y_RES: rdata_nxt = y_res_r;
         hall_regs_pkg::ADDR_Z_RES: rdata_nxt = z_res_r;
         hall_regs_pkg::ADDR_T_RES: rdata_nxt = t_res_r;
         hall_regs_pkg::ADDR_AFE: rdata_nxt = afe_r;
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // Limit crossings
   // Full scale maps onto the upper result byte, so comparing that byte with
   // the code gives range/128 per step whatever range is selected.
   assign z_beyond = ($signed(z_res_r[15:8]) > $signed(z_thr_r[15:8]))
      || ($signed(z_res_r[15:8]) < $signed(z_thr_r[7:0]));
   assign t_beyond = ($signed(temp_code_in) > $signed(t_thr_r[15:8]))
      || ($signed(temp_code_in) < $signed(t_thr_r[7:0]));
   assign need = {1'b0, limit_crossing_count} + 3'h1;

   // Runs saturate at four so a long excursion cannot wrap back to zero.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         z_run_r <= 3'h0;
         t_run_r <= 3'h0;
      end else if (conv_done) begin
         z_run_r <= !(($signed(z_sample_in[15:8]) > $signed(z_thr_r[15:8]))
            || ($signed(z_sample_in[15:8]) < $signed(z_thr_r[7:0]))) ? 3'h0 :
            (z_run_r == 3'h4) ? 3'h4 : z_run_r + 3'h1;
         t_run_r <= !t_beyond ? 3'h0 : (t_run_r == 3'h4) ? 3'h4 : t_run_r + 3'h1;
      end
   end

   // ==========================================================
   // Alert response
   assign alert_cond = (z_limit_alert_en && z_beyond && z_run_r >= need)
      || (temp_limit_alert_en && t_beyond && t_run_r >= need)
      || (status_alert_en && summary_r != 2'h0);
   assign ack_rd = reg_rd && is_ack_addr(reg_addr);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         alert_r <= 1'b0;
      end else if (!alert_latch) begin
         alert_r <= alert_cond;
      end else if (alert_cond) begin
         alert_r <= 1'b1;
      end else if (ack_rd) begin
         alert_r <= 1'b0;
      end
   end

   assign reg_rdata = rdata_r;
   assign z_upper_limit = z_thr_r[15:8];
   assign z_lower_limit = z_thr_r[7:0];
   assign temp_upper_limit = t_thr_r[15:8];
   assign temp_lower_limit = t_thr_r[7:0];
   assign alert_cause_summary = summary_r;
   assign alert_resp = alert_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence wr_z_s;
      reg_wr && reg_addr == hall_regs_pkg::ADDR_Z_THR;
   endsequence
   sequence wr_t_s;
      reg_wr && reg_addr == hall_regs_pkg::ADDR_T_THR;
   endsequence
   sequence afe_read_s;
      reg_rd && reg_addr == hall_regs_pkg::ADDR_AFE && !afe_fault[6];
   endsequence
   // A start in the same cycle as a finish loses, so only a lone start clears.
   sequence conv_begin_s;
      conv_start && !conv_done;
   endsequence

   z_upper_write_a: assert property (wr_z_s |=> z_upper_limit == $past(reg_wdata[15:8]))
      else $error("Z upper limit not stored.");
   z_lower_write_a: assert property (wr_z_s |=> z_lower_limit == $past(reg_wdata[7:0]))
      else $error("Z lower limit not stored.");
   temp_limit_write_a: assert property (wr_t_s |=>
      {temp_upper_limit, temp_lower_limit} == $past(reg_wdata))
      else $error("Temperature limits not stored.");
   // Writes are the only way the limit registers may move.
   limit_hold_a: assert property (!reg_wr |=> $stable(z_thr_r) && $stable(t_thr_r))
      else $error("Limit register changed without a write.");
   ready_flag_a: assert property (conv_done |=> rdy_r)
      else $error("Ready flag not set after conversion.");
   ready_clear_a: assert property (conv_begin_s |=> !rdy_r && cur_r == 5'h00)
      else $error("Ready or current flags not cleared at start.");
   current_flags_a: assert property (conv_done |=> cur_r == $past(chan_current))
      else $error("Current flags not loaded.");
   set_count_a: assert property (conv_done |=> set_cnt_r == $past(set_cnt_r) + 3'h1)
      else $error("Set count did not advance.");
   count_hold_a: assert property (!conv_done |=> $stable(set_cnt_r))
      else $error("Set count moved without a conversion.");
   // The first edge after release still samples the reset value of the summary, so it is skipped.
   summary_code_a: assert property (reset_n && $past(reset_n) |->
      alert_cause_summary == {$past(sys_flag_any), |$past(afe_r)})
      else $error("Alert summary code wrong.");
   status_alert_a: assert property (status_alert_en && alert_cause_summary != 2'h0
      |=> alert_resp)
      else $error("Status alert not raised.");
   result_ro_a: assert property (reg_wr && !conv_done |=>
      $stable(x_res_r) && $stable(y_res_r) && $stable(z_res_r) && $stable(t_res_r))
      else $error("Result changed without conversion.");
   pwrup_clear_a: assert property (afe_read_s |=> !afe_r[hall_regs_pkg::AFE_PWRUP_BIT])
      else $error("Power-up bit not cleared by read.");
   afe_clear_a: assert property (afe_read_s ##0 afe_fault == 7'h00 |=>
      afe_r == 16'h0000)
      else $error("Front-end status not cleared by read.");
   latch_hold_a: assert property (alert_latch && alert_r && !ack_rd |=> alert_r)
      else $error("Latched alert dropped without read.");
   crossing_gate_a: assert property (!alert_latch && !status_alert_en
      && !temp_limit_alert_en && z_run_r < need |=> !alert_r)
      else $error("Alert before crossing count reached.");

endmodule

// >>> verification/host_model.sv
// Register-port host model: single write and read strobes on clk_sys.
// Assumes the bench calls its tasks only after reset has been released.
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk_sys,
   // Register requests
   output logic [3:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // ==========================================================
   // Requests
   // The address, and after a write the data, are inverted when a strobe drops, so a late sample
   // never sees a stale value that happens to match.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      reg_addr <= ~a;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask
endmodule

// >>> verification/tb_threshold_result_status_regs.sv
// Self-checking bench for the threshold, status and result registers.
// Assumes one core clock; the host model issues every register request.
`timescale 1ns/1ps
module tb_threshold_result_status_regs;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, alert_resp;
   logic rd_d = 1'b0;
   logic conv_start = 1'b0, conv_done = 1'b0, sys_flag_any = 1'b0, alert_latch = 1'b0;
   logic status_alert_en = 1'b0, z_limit_alert_en = 1'b0, temp_limit_alert_en = 1'b0;
   logic [4:0] chan_current = 5'h00;
   logic [15:0] xs = 16'h0000, ys = 16'h0000, zs = 16'h0000, ts = 16'h0000;
   logic [7:0] temp_code_in = 8'h40;
   logic [7:0] zu, zl, tu, tl;
   logic [6:0] afe_fault = 7'h00;
   logic [1:0] limit_crossing_count = 2'h0;
   logic [1:0] sum;
   logic [2:0] cnt = 3'h0;
   logic [15:0] expq[$];
   int fails = 0, checks_done = 0, cyc = 0;
   always #10 clk_sys = ~clk_sys;
   host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   threshold_result_status_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_done(conv_done),
      .chan_current(chan_current), .x_sample_in(xs), .y_sample_in(ys), .z_sample_in(zs),
      .temp_sample_in(ts), .temp_code_in(temp_code_in), .afe_fault(afe_fault),
      .sys_flag_any(sys_flag_any), .alert_latch(alert_latch),
      .status_alert_en(status_alert_en), .z_limit_alert_en(z_limit_alert_en),
      .temp_limit_alert_en(temp_limit_alert_en), .limit_crossing_count(limit_crossing_count),
      .z_upper_limit(zu), .z_lower_limit(zl), .temp_upper_limit(tu), .temp_lower_limit(tl),
      .alert_cause_summary(sum), .alert_resp(alert_resp));
   // ==========================================================
   // Checking
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Read data arrives one edge after the strobe, so it is judged a half cycle later.
   always @(negedge clk_sys) begin
      if (rd_d && expq.size() > 0)
         check(reg_rdata, expq.pop_front());
   end
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
      cyc++;
      if (cyc == 3000) begin
         fails++;
         final_report();
      end
   end
   // ==========================================================
   // Stimulus helpers
   task automatic rd_exp(input logic [3:0] a, input logic [15:0] e);
      expq.push_back(e);
      host_u.rd(a);
   endtask
   function automatic logic [15:0] conv_word(input logic rdy, input logic [1:0] s);
      return {2'b00, rdy, rdy ? chan_current : 5'h00, 1'b0, cnt, 2'b00, s};
   endfunction
   task automatic cstart();
      @(posedge clk_sys);
      conv_start <= 1'b1;
      @(posedge clk_sys);
      conv_start <= 1'b0;
   endtask
   task automatic cdone(input logic [15:0] z);
      @(posedge clk_sys);
      conv_done <= 1'b1;
      chan_current <= 5'($urandom);
      xs <= 16'($urandom);
      ys <= 16'($urandom);
      ts <= 16'($urandom);
      zs <= z;
      @(posedge clk_sys);
      conv_done <= 1'b0;
      cnt = cnt + 3'h1;
   endtask
   task automatic alert_is(input logic e);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check({15'h0000, alert_resp}, {15'h0000, e});
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(85));
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      check({zu, zl}, 16'h7d83);
      check({tu, tl}, 16'h6732);
      rd_exp(4'h6, 16'h7d83);
      rd_exp(4'h7, 16'h6732);
      rd_exp(4'h8, conv_word(1'b0, 2'b01));
      for (int a = 9; a < 13; a++) rd_exp(4'(a), 16'h0000);
      for (int a = 8; a < 14; a++) host_u.wr(4'(a), 16'($urandom));
      host_u.wr(4'h0, 16'hffff);
      rd_exp(4'h0, 16'h0000);
      rd_exp(4'hb, 16'h0000);
      rd_exp(4'hd, 16'h8000);
      rd_exp(4'hd, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         d = 16'($urandom);
         host_u.wr(4'(6 + i), d);
         rd_exp(4'(6 + i), d);
      end
      check({tu, tl}, d);
      for (int i = 0; i < 9; i++) begin
         cstart();
         if (i == 0) rd_exp(4'h8, conv_word(1'b0, 2'b00));
         cdone(16'($urandom));
         rd_exp(4'h8, conv_word(1'b1, 2'b00));
      end
      rd_exp(4'h9, xs);
      rd_exp(4'ha, ys);
      rd_exp(4'hb, zs);
      rd_exp(4'hc, ts);
      status_alert_en <= 1'b1;
      afe_fault <= 7'h01;
      @(posedge clk_sys);
      afe_fault <= 7'h00;
      alert_is(1'b1);
      check({14'h0000, sum}, 16'h0001);
      rd_exp(4'h8, conv_word(1'b1, 2'b01));
      sys_flag_any <= 1'b1;
      alert_is(1'b1);
      check({14'h0000, sum}, 16'h0003);
      rd_exp(4'h8, conv_word(1'b1, 2'b11));
      rd_exp(4'hd, 16'h0001);
      alert_is(1'b1);
      check({14'h0000, sum}, 16'h0002);
      rd_exp(4'h8, conv_word(1'b1, 2'b10));
      sys_flag_any <= 1'b0;
      status_alert_en <= 1'b0;
      alert_is(1'b0);
      check({14'h0000, sum}, 16'h0000);
      host_u.wr(4'h6, 16'h1080);
      host_u.wr(4'h7, 16'h7f80);
      z_limit_alert_en <= 1'b1;
      temp_limit_alert_en <= 1'b1;
      limit_crossing_count <= 2'h1;
      // A set inside the limits clears runs left over from the random sets.
      cstart();
      cdone(16'h0000);
      for (int m = 0; m < 2; m++) begin
         alert_latch <= m[0];
         cstart();
         cdone(16'h2000);
         alert_is(1'b0);
         cstart();
         cdone(16'h2000);
         alert_is(1'b1);
         cstart();
         cdone(16'h0000);
         alert_is(m[0]);
      end
      rd_exp(4'h8, conv_word(1'b1, 2'b00));
      alert_is(1'b0);
      // A reset in mid-run must bring back the power-up values.
      @(posedge clk_sys);
      reset_n <= 1'b0;
      @(posedge clk_sys);
      reset_n <= 1'b1;
      rd_exp(4'h6, 16'h7d83);
      rd_exp(4'hd, 16'h8000);
      repeat (4) @(posedge clk_sys);
      final_report();
   end
endmodule
